// >>> include/pio_pkg.sv
// package: address map, field layout and reset values of the parallel port block
// ==========================================================================
// How it works
// [RL1] three ports hold eighteen pins, every pin under its own control.
// [RL2] an enabled shared peripheral takes over its pin from the port logic.
// [RL3] reset frees all pins to the port logic, except debug and reset pins.
// [RL4] reset clears every input, output and pullup enable, so pins float.
// [RL5] reset clears the high drive setting, so no pin drives strongly.
// [RL6] each pin has its own input enable and output enable bit.
// [RL7] data read gives pin level when input enabled and output disabled, else written value.
// [RL8] with input and output both enabled a data read gives written value.
// [RL9] software keeps output enable clear while a pin serves as an input.
// [RL10] port enable bits decide read-back even while a peripheral owns the pin.
// [RL11] analog function blocks digital use of a pin and reads back zero.
// [RL12] analog function wins over an alternate digital function on a pin.
// [RL13] software writes data before it sets a pin's output enable.
// [RL14] every data write is stored whole; output pins drive the stored level (here only the port's implemented bits are stored).
// [RL15] pullup is off while the pin is an output of port or peripheral.
// [RL16] pullup is off while an analog function owns the pin.
// [RL17] reset clears data to zero without driving it onto the pins.
// [RL18] pin levels are synchronised to the bus clock before they are read.
package pio_pkg;
	// ==========================================================================
	// geometry
	localparam int NUM_PORTS  = 3;
	localparam int NUM_PINS   = 18;
	localparam int REG_W      = 8;
	localparam int ADDR_W     = 16;
	localparam int IDX_W      = 2;
	localparam int PORT_A_W   = 6;
	localparam int PORT_B_W   = 8;
	localparam int PORT_C_W   = 4;
	localparam int PORT_B_LSB = 6;
	localparam int PORT_C_LSB = 14;
	localparam int HDRV_W     = 2;
	localparam int HDRV_LSB   = 10;
	localparam int SYSFN_W    = 2;
	localparam int PIN_DBG    = 4;
	localparam int PIN_RST    = 5;
	localparam int SYSFN_DBG  = 0;
	localparam int SYSFN_RST  = 1;

	// ==========================================================================
	// register map
	localparam logic [ADDR_W-1:0] ADDR_DATA  = 16'h0000;
	localparam logic [ADDR_W-1:0] ADDR_HDRV  = 16'h30AF;
	localparam logic [ADDR_W-1:0] ADDR_OE    = 16'h30B0;
	localparam logic [ADDR_W-1:0] ADDR_IE    = 16'h30B8;
	localparam logic [ADDR_W-1:0] ADDR_SYSFN = 16'h30C0;
	localparam logic [ADDR_W-1:0] ADDR_PE    = 16'h30F0;
	localparam logic [ADDR_W-1:0] PORT_LAST  = 16'h0002;

	// ==========================================================================
	// reset values and masks
	localparam logic [REG_W-1:0]   RST_REG   = 8'h00;
	localparam logic [SYSFN_W-1:0] RST_SYSFN = 2'h3;
	localparam logic [REG_W-1:0]   MASK_A    = 8'h3F;
	localparam logic [REG_W-1:0]   MASK_B    = 8'hFF;
	localparam logic [REG_W-1:0]   MASK_C    = 8'h0F;

	typedef enum logic [2:0] {
		PIO_REG_NONE,
		PIO_REG_DATA,
		PIO_REG_OE,
		PIO_REG_IE,
		PIO_REG_PE,
		PIO_REG_HDRV,
		PIO_REG_SYSFN
	} pio_reg_e;
endpackage : pio_pkg

// >>> rtl/pio_sync.sv
// two-stage synchroniser for the asynchronous pin levels
`timescale 1ns/1ps
`default_nettype none
module pio_sync #(
	parameter int W = 18
) (
	// clock and reset
	input  wire logic         sys_clk,
	input  wire logic         rst_n,
	// levels
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	// ==========================================================================
	// flops
	logic [W-1:0] meta;
	logic [W-1:0] next_meta;
	logic [W-1:0] next_sync;

	// the first stage feeds only the second, nothing else looks at it
	always_comb begin
		next_meta = async_in;
		next_sync = meta;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			meta     <= '0;
			sync_out <= '0;
		end else begin
			meta     <= next_meta; // see RL18
			sync_out <= next_sync;
		end
	end
endmodule : pio_sync
`default_nettype wire

// >>> rtl/pio_pin_mux.sv
// per-pin ownership mux: analog over peripheral over port logic
`timescale 1ns/1ps
`default_nettype none
module pio_pin_mux (
	// port logic settings, flat over all pins
	input  wire logic [pio_pkg::NUM_PINS-1:0] data_flat,
	input  wire logic [pio_pkg::NUM_PINS-1:0] oe_flat,
	input  wire logic [pio_pkg::NUM_PINS-1:0] pe_flat,
	input  wire logic [pio_pkg::HDRV_W-1:0]   hdrv_sel,
	// owners that override the port logic
	input  wire logic [pio_pkg::NUM_PINS-1:0] own_en,
	input  wire logic [pio_pkg::NUM_PINS-1:0] own_oe,
	input  wire logic [pio_pkg::NUM_PINS-1:0] own_out,
	input  wire logic [pio_pkg::NUM_PINS-1:0] analog_en,
	// pad controls
	output logic      [pio_pkg::NUM_PINS-1:0] pin_out,
	output logic      [pio_pkg::NUM_PINS-1:0] pin_oe,
	output logic      [pio_pkg::NUM_PINS-1:0] pin_pullup,
	output logic      [pio_pkg::HDRV_W-1:0]   pin_hdrv
);
	// ==========================================================================
	// pad drive
	// analog owner masks every digital path, so it outranks peripherals
	always_comb begin
		pin_oe     = ~analog_en & ((own_en & own_oe) | (~own_en & oe_flat)); // see RL2
		pin_out    = ~analog_en & ((own_en & own_out) | (~own_en & data_flat)); // see RL14
		pin_pullup = pe_flat & ~pin_oe & ~analog_en; // see RL15, RL16
		// high drive only acts while the pin really drives
		pin_hdrv   = hdrv_sel & pin_oe[pio_pkg::HDRV_LSB +: pio_pkg::HDRV_W];
	end
endmodule : pio_pin_mux
`default_nettype wire

// >>> rtl/pio_port_ctrl.sv
// parallel port control: registers, read-back and pin ownership
//
// Our own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module pio_port_ctrl (
	// clock and reset
	input  wire logic                          sys_clk,
	input  wire logic                          rst_n,
	// register port
	input  wire logic [pio_pkg::ADDR_W-1:0]    addr,
	input  wire logic [pio_pkg::REG_W-1:0]     wdata,
	input  wire logic                          wr_en,
	input  wire logic                          rd_en,
	output logic      [pio_pkg::REG_W-1:0]     rdata,
	// pads
	input  wire logic [pio_pkg::NUM_PINS-1:0]  pin_in,
	output logic      [pio_pkg::NUM_PINS-1:0]  pin_out,
	output logic      [pio_pkg::NUM_PINS-1:0]  pin_oe,
	output logic      [pio_pkg::NUM_PINS-1:0]  pin_pullup,
	output logic      [pio_pkg::HDRV_W-1:0]    pin_hdrv,
	// shared peripherals and analog functions
	input  wire logic [pio_pkg::NUM_PINS-1:0]  periph_en,
	input  wire logic [pio_pkg::NUM_PINS-1:0]  periph_oe,
	input  wire logic [pio_pkg::NUM_PINS-1:0]  periph_out,
	input  wire logic [pio_pkg::NUM_PINS-1:0]  analog_en,
	output logic      [pio_pkg::NUM_PINS-1:0]  pin_sync,
	output logic      [pio_pkg::SYSFN_W-1:0]   sys_fn_en
);
	// ==========================================================================
	// helpers
	function automatic pio_pkg::pio_reg_e reg_kind(input logic [pio_pkg::ADDR_W-1:0] a);
		logic [pio_pkg::ADDR_W-1:0] l;
		l = pio_pkg::PORT_LAST;
		if (a >= pio_pkg::ADDR_DATA && a <= pio_pkg::ADDR_DATA + l) begin
			reg_kind = pio_pkg::PIO_REG_DATA;
		end else if (a >= pio_pkg::ADDR_OE && a <= pio_pkg::ADDR_OE + l) begin
			reg_kind = pio_pkg::PIO_REG_OE;
		end else if (a >= pio_pkg::ADDR_IE && a <= pio_pkg::ADDR_IE + l) begin
			reg_kind = pio_pkg::PIO_REG_IE;
		end else if (a >= pio_pkg::ADDR_PE && a <= pio_pkg::ADDR_PE + l) begin
			reg_kind = pio_pkg::PIO_REG_PE;
		end else if (a == pio_pkg::ADDR_HDRV) begin
			reg_kind = pio_pkg::PIO_REG_HDRV;
		end else if (a == pio_pkg::ADDR_SYSFN) begin
			reg_kind = pio_pkg::PIO_REG_SYSFN;
		end else begin
			reg_kind = pio_pkg::PIO_REG_NONE;
		end
	endfunction : reg_kind

	// implemented bits of each port; unbonded bits read as zero
	function automatic logic [pio_pkg::REG_W-1:0] port_mask(input logic [pio_pkg::IDX_W-1:0] i);
		case (i)
			2'h0:    port_mask = pio_pkg::MASK_A;
			2'h1:    port_mask = pio_pkg::MASK_B;
			2'h2:    port_mask = pio_pkg::MASK_C;
			default: port_mask = pio_pkg::RST_REG;
		endcase
	endfunction : port_mask

	// three per-port bytes to one flat pin vector
	function automatic logic [pio_pkg::NUM_PINS-1:0] to_flat(
		input logic [pio_pkg::REG_W-1:0] a,
		input logic [pio_pkg::REG_W-1:0] b,
		input logic [pio_pkg::REG_W-1:0] c
	);
		to_flat = {c[pio_pkg::PORT_C_W-1:0], b[pio_pkg::PORT_B_W-1:0], a[pio_pkg::PORT_A_W-1:0]};
	endfunction : to_flat

	// one port's byte out of a flat pin vector
	function automatic logic [pio_pkg::REG_W-1:0] from_flat(
		input logic [pio_pkg::NUM_PINS-1:0] v,
		input logic [pio_pkg::IDX_W-1:0]    i
	);
		from_flat = pio_pkg::RST_REG;
		case (i)
			2'h0:    from_flat[pio_pkg::PORT_A_W-1:0] = v[pio_pkg::PORT_A_W-1:0];
			2'h1:    from_flat = v[pio_pkg::PORT_B_LSB +: pio_pkg::PORT_B_W];
			2'h2:    from_flat[pio_pkg::PORT_C_W-1:0] = v[pio_pkg::PORT_C_LSB +: pio_pkg::PORT_C_W];
			default: from_flat = pio_pkg::RST_REG;
		endcase
	endfunction : from_flat

	// ==========================================================================
	// register state
	logic [pio_pkg::REG_W-1:0]   data_r [pio_pkg::NUM_PORTS];
	logic [pio_pkg::REG_W-1:0]   oe_r   [pio_pkg::NUM_PORTS];
	logic [pio_pkg::REG_W-1:0]   ie_r   [pio_pkg::NUM_PORTS];
	logic [pio_pkg::REG_W-1:0]   pe_r   [pio_pkg::NUM_PORTS];
	logic [pio_pkg::REG_W-1:0]   hdrv_r;
	logic [pio_pkg::SYSFN_W-1:0] sysfn_r;
	logic [pio_pkg::REG_W-1:0]   next_data [pio_pkg::NUM_PORTS];
	logic [pio_pkg::REG_W-1:0]   next_oe   [pio_pkg::NUM_PORTS];
	logic [pio_pkg::REG_W-1:0]   next_ie   [pio_pkg::NUM_PORTS];
	logic [pio_pkg::REG_W-1:0]   next_pe   [pio_pkg::NUM_PORTS];
	logic [pio_pkg::REG_W-1:0]   next_hdrv;
	logic [pio_pkg::SYSFN_W-1:0] next_sysfn;
	logic [pio_pkg::REG_W-1:0]   next_rdata;
	pio_pkg::pio_reg_e           kind;
	logic [pio_pkg::IDX_W-1:0]   idx;
	logic [pio_pkg::REG_W-1:0]   mask;
	logic [pio_pkg::NUM_PINS-1:0] data_flat;
	logic [pio_pkg::NUM_PINS-1:0] oe_flat;
	logic [pio_pkg::NUM_PINS-1:0] ie_flat;
	logic [pio_pkg::NUM_PINS-1:0] pe_flat;
	logic [pio_pkg::NUM_PINS-1:0] sys_own;
	logic [pio_pkg::NUM_PINS-1:0] own_en;
	logic [pio_pkg::NUM_PINS-1:0] rd_pins;

	// decode; every port base has its port index in the low address bits
	always_comb begin
		kind = reg_kind(addr);
		idx  = addr[pio_pkg::IDX_W-1:0];
		mask = port_mask(idx);
	end

	// flat views and ownership; system functions own the debug and reset pins
	always_comb begin
		data_flat = to_flat(data_r[0], data_r[1], data_r[2]); // see RL1
		oe_flat   = to_flat(oe_r[0], oe_r[1], oe_r[2]);
		ie_flat   = to_flat(ie_r[0], ie_r[1], ie_r[2]);
		pe_flat   = to_flat(pe_r[0], pe_r[1], pe_r[2]);
		sys_own   = '0;
		sys_own[pio_pkg::PIN_DBG] = sysfn_r[pio_pkg::SYSFN_DBG]; // see RL3
		sys_own[pio_pkg::PIN_RST] = sysfn_r[pio_pkg::SYSFN_RST]; // see RL3
		own_en    = periph_en | sys_own;
		sys_fn_en = sysfn_r;
	end

	// read-back follows the port's own enable bits, never the owner's direction
	// pin level only when input on and output off; analog pins read zero
	always_comb begin
		rd_pins = ~analog_en & ((ie_flat & ~oe_flat & pin_sync) // see RL7
			| (~(ie_flat & ~oe_flat) & data_flat)); // see RL8, RL10, RL11
	end

	// ==========================================================================
	// register writes and read data
	always_comb begin
		next_data  = data_r;
		next_oe    = oe_r;
		next_ie    = ie_r;
		next_pe    = pe_r;
		next_hdrv  = hdrv_r;
		next_sysfn = sysfn_r;
		next_rdata = pio_pkg::RST_REG;
		if (wr_en) begin
			case (kind)
				pio_pkg::PIO_REG_DATA:  next_data[idx] = wdata & mask; // see RL14
				pio_pkg::PIO_REG_OE:    next_oe[idx]   = wdata & mask; // see RL6
				pio_pkg::PIO_REG_IE:    next_ie[idx]   = wdata & mask; // see RL6
				pio_pkg::PIO_REG_PE:    next_pe[idx]   = wdata & mask;
				pio_pkg::PIO_REG_HDRV:  next_hdrv      = wdata;
				pio_pkg::PIO_REG_SYSFN: next_sysfn     = wdata[pio_pkg::SYSFN_W-1:0];
				default:                next_hdrv      = hdrv_r;
			endcase
		end
		// unmapped addresses read zero
		if (rd_en) begin
			case (kind)
				pio_pkg::PIO_REG_DATA:  next_rdata = from_flat(rd_pins, idx);
				pio_pkg::PIO_REG_OE:    next_rdata = oe_r[idx];
				pio_pkg::PIO_REG_IE:    next_rdata = ie_r[idx];
				pio_pkg::PIO_REG_PE:    next_rdata = pe_r[idx];
				pio_pkg::PIO_REG_HDRV:  next_rdata = hdrv_r;
				pio_pkg::PIO_REG_SYSFN: next_rdata[pio_pkg::SYSFN_W-1:0] = sysfn_r;
				default:                next_rdata = pio_pkg::RST_REG;
			endcase
		end
	end

	// reset leaves port-owned pins floating with zero data held behind them; debug and reset pins go to system functions
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			for (int i = 0; i < pio_pkg::NUM_PORTS; i++) begin
				data_r[i] <= pio_pkg::RST_REG; // see RL17
				oe_r[i]   <= pio_pkg::RST_REG; // see RL4
				ie_r[i]   <= pio_pkg::RST_REG; // see RL4
				pe_r[i]   <= pio_pkg::RST_REG; // see RL4
			end
			hdrv_r  <= pio_pkg::RST_REG; // see RL5
			sysfn_r <= pio_pkg::RST_SYSFN; // see RL3
			rdata   <= pio_pkg::RST_REG;
		end else begin
			data_r  <= next_data;
			oe_r    <= next_oe;
			ie_r    <= next_ie;
			pe_r    <= next_pe;
			hdrv_r  <= next_hdrv;
			sysfn_r <= next_sysfn;
			rdata   <= next_rdata;
		end
	end

	// ==========================================================================
	// submodules
	// pin levels cross into the bus clock before any read sees them
	pio_sync #(
		.W(pio_pkg::NUM_PINS)
	) u_sync (
		.sys_clk  (sys_clk),
		.rst_n    (rst_n),
		.async_in (pin_in),
		.sync_out (pin_sync) // see RL18
	);

	pio_pin_mux u_mux (
		.data_flat  (data_flat),
		.oe_flat    (oe_flat),
		.pe_flat    (pe_flat),
		.hdrv_sel   (hdrv_r[pio_pkg::HDRV_W-1:0]),
		.own_en     (own_en), // see RL2
		.own_oe     (periph_oe),
		.own_out    (periph_out),
		.analog_en  (analog_en), // see RL12
		.pin_out    (pin_out),
		.pin_oe     (pin_oe),
		.pin_pullup (pin_pullup),
		.pin_hdrv   (pin_hdrv)
	);

	// ==========================================================================
	// checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	a_reset_hiz: assert property ( // see RL4, RL17
		$past(!rst_n) |-> (data_flat == '0) && (oe_flat == '0) && (pe_flat == '0)
			&& (hdrv_r == pio_pkg::RST_REG) && (sysfn_r == pio_pkg::RST_SYSFN)
	) else $error("registers not cleared by reset");

	a_owner_drives: assert property ( // see RL2
		((pin_oe ^ periph_oe) & periph_en & ~analog_en) == '0
	) else $error("peripheral does not own its pin direction");

	a_analog_wins: assert property ( // see RL12
		((pin_oe | pin_out) & analog_en) == '0
	) else $error("digital drive on analog pin");

	a_pullup_off: assert property ( // see RL15, RL16
		((pin_pullup & pin_oe) | (pin_pullup & analog_en)) == '0
	) else $error("pullup on while output or analog");

	a_drive_latch: assert property ( // see RL14
		wr_en && addr == pio_pkg::ADDR_DATA && oe_r[0] == pio_pkg::MASK_A
			&& own_en[pio_pkg::PORT_A_W-1:0] == '0 && analog_en[pio_pkg::PORT_A_W-1:0] == '0
		|=> pin_out[pio_pkg::PORT_A_W-1:0] == $past(wdata[pio_pkg::PORT_A_W-1:0])
	) else $error("written data not driven on port a");

	a_read_latch: assert property ( // see RL7
		rd_en && addr == pio_pkg::ADDR_DATA && ie_r[0] == pio_pkg::RST_REG
			&& analog_en[pio_pkg::PORT_A_W-1:0] == '0
		|=> rdata == ($past(data_r[0]) & pio_pkg::MASK_A)
	) else $error("read of non-input pins not the stored data");

	a_read_both_en: assert property ( // see RL8
		rd_en && addr == pio_pkg::ADDR_DATA + pio_pkg::PORT_LAST - 16'h0001
			&& ie_r[1] == pio_pkg::MASK_B && oe_r[1] == pio_pkg::MASK_B
			&& analog_en[pio_pkg::PORT_B_LSB +: pio_pkg::PORT_B_W] == '0
		|=> rdata == $past(data_r[1])
	) else $error("in-and-out pin did not read output data");

	a_read_pin_sync: assert property ( // see RL18
		rd_en && addr == pio_pkg::ADDR_DATA && ie_r[0] == pio_pkg::MASK_A
			&& oe_r[0] == pio_pkg::RST_REG && analog_en[pio_pkg::PORT_A_W-1:0] == '0
			&& $past(rst_n, 2)
		|=> rdata[pio_pkg::PORT_A_W-1:0] == $past(pin_in[pio_pkg::PORT_A_W-1:0], 3)
	) else $error("pin read not two cycles synchronised");

	a_analog_reads0: assert property ( // see RL11
		rd_en && addr == pio_pkg::ADDR_DATA
		|=> (rdata[pio_pkg::PORT_A_W-1:0] & $past(analog_en[pio_pkg::PORT_A_W-1:0])) == '0
	) else $error("analog pin read back nonzero");

	a_read_own_dir: assert property ( // see RL10
		rd_en && addr == pio_pkg::ADDR_DATA && own_en[pio_pkg::PORT_A_W-1:0] != '0
			&& ie_r[0] == pio_pkg::RST_REG && analog_en[pio_pkg::PORT_A_W-1:0] == '0
		|=> rdata == ($past(data_r[0]) & pio_pkg::MASK_A)
	) else $error("owner direction leaked into read-back");
endmodule : pio_port_ctrl
`default_nettype wire

// >>> tb/pio_pin_model.sv
// partner model: the pads and the outside world that drives them
`timescale 1ns/1ps
`default_nettype none
module pio_pin_model (
	// clock
	input  wire logic [0:0]                   sys_clk,
	// pad controls from the port
	input  wire logic [pio_pkg::NUM_PINS-1:0] pin_out,
	input  wire logic [pio_pkg::NUM_PINS-1:0] pin_oe,
	input  wire logic [pio_pkg::NUM_PINS-1:0] pin_pullup,
	// outside drivers
	input  wire logic [pio_pkg::NUM_PINS-1:0] ext_en,
	input  wire logic [pio_pkg::NUM_PINS-1:0] ext_val,
	// resolved pad levels
	output logic      [pio_pkg::NUM_PINS-1:0] pin_in
);
	logic [pio_pkg::NUM_PINS-1:0] float_lvl;

	// ==========================================================================
	// floating pads
	// an undriven pad wanders every cycle, so a stale level never looks settled
	initial float_lvl = 18'h2AAAA;
	always @(posedge sys_clk) begin
		float_lvl <= ~float_lvl;
	end

	// ==========================================================================
	// pad resolution: port drive, then outside drive, then pullup, else floating
	always_comb begin
		for (int i = 0; i < pio_pkg::NUM_PINS; i++) begin
			if (pin_oe[i]) begin
				pin_in[i] = pin_out[i];
			end else if (ext_en[i]) begin
				pin_in[i] = ext_val[i];
			end else if (pin_pullup[i]) begin
				pin_in[i] = 1'b1;
			end else begin
				pin_in[i] = float_lvl[i];
			end
		end
	end
endmodule : pio_pin_model
`default_nettype wire

// >>> tb/tb_parallel_io_port_control.sv
// self-checking testbench for the parallel port control block
`timescale 1ns/1ps
`default_nettype none
module tb_parallel_io_port_control;
	logic                          sys_clk    = 1'b0;
	logic                          rst_n      = 1'b0;
	logic [pio_pkg::ADDR_W-1:0]    addr       = 16'h0000;
	logic [pio_pkg::REG_W-1:0]     wdata      = 8'h00;
	logic                          wr_en      = 1'b0;
	logic                          rd_en      = 1'b0;
	logic [pio_pkg::REG_W-1:0]     rdata;
	logic [pio_pkg::NUM_PINS-1:0]  pin_in, pin_out, pin_oe, pin_pullup, pin_sync;
	logic [pio_pkg::HDRV_W-1:0]    pin_hdrv;
	logic [pio_pkg::SYSFN_W-1:0]   sys_fn_en;
	logic [pio_pkg::NUM_PINS-1:0]  periph_en  = 18'h00000;
	logic [pio_pkg::NUM_PINS-1:0]  periph_oe  = 18'h00000;
	logic [pio_pkg::NUM_PINS-1:0]  periph_out = 18'h00000;
	logic [pio_pkg::NUM_PINS-1:0]  analog_en  = 18'h00000;
	logic [pio_pkg::NUM_PINS-1:0]  ext_en     = 18'h00000;
	logic [pio_pkg::NUM_PINS-1:0]  ext_val    = 18'h00000;
	int                            num_errors = 0;
	int                            compares   = 0;
	// every register, with the bits that survive a write of all ones
	logic [15:0] regs [14] = '{16'h0000, 16'h0001, 16'h0002, 16'h30AF, 16'h30B0, 16'h30B1,
		16'h30B2, 16'h30B8, 16'h30B9, 16'h30BA, 16'h30C0, 16'h30F0, 16'h30F1, 16'h30F2};
	logic [7:0]  masks [14] = '{8'h3F, 8'hFF, 8'h0F, 8'hFF, 8'h3F, 8'hFF, 8'h0F,
		8'h3F, 8'hFF, 8'h0F, 8'h03, 8'h3F, 8'hFF, 8'h0F};

	// ==========================================================================
	// clock, design and pads
	always #5 sys_clk = ~sys_clk;

	pio_port_ctrl pio_port_ctrl_inst (.sys_clk(sys_clk), .rst_n(rst_n), .addr(addr),
		.wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .pin_in(pin_in),
		.pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup), .pin_hdrv(pin_hdrv),
		.periph_en(periph_en), .periph_oe(periph_oe), .periph_out(periph_out),
		.analog_en(analog_en), .pin_sync(pin_sync), .sys_fn_en(sys_fn_en));

	pio_pin_model pio_pin_model_inst (.sys_clk(sys_clk), .pin_out(pin_out), .pin_oe(pin_oe),
		.pin_pullup(pin_pullup), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));

	// ==========================================================================
	// shared tasks
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %s expected %0h seen %0h", what, exp, seen);
		end
	endtask : chk

	// one-cycle write strobe; returns just after the edge that takes it
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge sys_clk);
		wr_en <= 1'b0;
		#1;
	endtask : wr

	// read data stand only in the cycle after the strobe, so look there
	task automatic rd(input logic [15:0] a, input logic [7:0] exp);
		@(posedge sys_clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge sys_clk);
		rd_en <= 1'b0;
		#1;
		chk($sformatf("rdata at %h", a), 32'(rdata), 32'(exp));
	endtask : rd

	task automatic finish_test();
		if (num_errors == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : finish_test

	// ==========================================================================
	// watchdog: the whole sequence needs under two hundred cycles
	initial begin
		repeat (3000) @(posedge sys_clk);
		num_errors++;
		finish_test();
	end

	// ==========================================================================
	// main sequence
	initial begin
		repeat (3) @(posedge sys_clk);
		rst_n <= 1'b1;
		#1;
		// state straight out of reset
		chk("pin_oe", 32'(pin_oe), 32'h0);
		chk("pin_pullup", 32'(pin_pullup), 32'h0);
		chk("pin_hdrv", 32'(pin_hdrv), 32'h0);
		chk("sys_fn_en", 32'(sys_fn_en), 32'h3);
		for (int i = 0; i < 14; i++) begin
			rd(regs[i], (i == 10) ? 8'h03 : 8'h00);
		end
		// all-ones write keeps only the implemented bits, then clear everything
		for (int i = 0; i < 14; i++) begin
			wr(regs[i], 8'hFF);
			rd(regs[i], masks[i]);
		end
		for (int i = 0; i < 14; i++) begin
			wr(regs[i], 8'h00);
		end
		// unmapped places ignore writes and read zero
		wr(16'h0003, 8'hFF);
		rd(16'h0003, 8'h00);
		wr(16'h30F8, 8'hFF);
		rd(16'h30F8, 8'h00);
		// port A as outputs: data first, then enables
		wr(16'h0000, 8'h15);
		wr(16'h30B0, 8'h3F);
		wr(16'h30F0, 8'h3F);
		chk("pin_oe A", 32'(pin_oe[5:0]), 32'h3F);
		chk("pin_out A", 32'(pin_out[5:0]), 32'h15);
		chk("pin_pullup A", 32'(pin_pullup[5:0]), 32'h00);
		rd(16'h0000, 8'h15);
		// a data write while the pins already drive goes straight out
		wr(16'h0000, 8'h2A);
		chk("pin_out A", 32'(pin_out[5:0]), 32'h2A);
		// port B as inputs driven from outside
		@(posedge sys_clk);
		ext_en <= 18'h3FC0;
		ext_val <= 18'h02940;
		wr(16'h30B9, 8'hFF);
		repeat (4) @(posedge sys_clk);
		rd(16'h0001, 8'hA5);
		chk("pin_sync B", 32'(pin_sync[13:6]), 32'hA5);
		// release outside drive before enabling outputs, so nothing fights
		ext_en <= 18'h00000;
		wr(16'h0001, 8'h3C);
		wr(16'h30B1, 8'hFF);
		rd(16'h0001, 8'h3C);
		// input with pullup and nothing driving reads high
		wr(16'h30B1, 8'h00);
		wr(16'h30F1, 8'hFF);
		chk("pin_pullup B", 32'(pin_pullup[13:6]), 32'hFF);
		repeat (4) @(posedge sys_clk);
		rd(16'h0001, 8'hFF);
		// peripheral takes port B as outputs
		@(posedge sys_clk);
		periph_en <= 18'h3FC0;
		periph_oe <= 18'h3FC0;
		periph_out <= 18'h030C0;
		#1;
		chk("pin_oe B", 32'(pin_oe[13:6]), 32'hFF);
		chk("pin_out B", 32'(pin_out[13:6]), 32'hC3);
		chk("pin_pullup B", 32'(pin_pullup[13:6]), 32'h00);
		wr(16'h30B1, 8'hFF);
		rd(16'h0001, 8'h3C);
		wr(16'h30AF, 8'h03);
		chk("pin_hdrv", 32'(pin_hdrv), 32'h3);
		// analog on pin B4 while the peripheral still claims it
		@(posedge sys_clk);
		analog_en <= 18'h00400;
		#1;
		chk("pin_oe B4", 32'(pin_oe[10]), 32'h0);
		chk("pin_out B4", 32'(pin_out[10]), 32'h0);
		chk("pin_hdrv", 32'(pin_hdrv), 32'h2);
		rd(16'h0001, 8'h2C);
		// port inputs with pullups; analog pin keeps its pullup off
		@(posedge sys_clk);
		periph_en <= 18'h00000;
		wr(16'h30B1, 8'h00);
		chk("pin_pullup B", 32'(pin_pullup[13:6]), 32'hEF);
		// port A back to pulled-up inputs, read through the synchroniser
		wr(16'h30B0, 8'h00);
		wr(16'h30B8, 8'h3F);
		repeat (4) @(posedge sys_clk);
		rd(16'h0000, 8'h3F);
		// analog on A0 against a high outside drive must still read zero
		@(posedge sys_clk);
		analog_en <= 18'h00401;
		ext_en <= 18'h00001;
		ext_val <= 18'h00001;
		#1;
		chk("pin_pullup A", 32'(pin_pullup[5:0]), 32'h3E);
		repeat (4) @(posedge sys_clk);
		rd(16'h0000, 8'h3E);
		finish_test();
	end
endmodule : tb_parallel_io_port_control
`default_nettype wire
